// ---- hw/sbc_pkg.sv ----
// Package: constants and state types of the standby mode controller
`default_nettype none
package sbc_pkg;

  localparam int SBC_CNT_W = 19;
  localparam int SBC_STS_W = 3;
  localparam int SBC_DIV_W = 2;
  localparam int SBC_PRE_W = 3;
  localparam int SBC_IRQ_N = 3;

  // Wait in divided-clock states, indexed by the settle time select.
  // Code 7 is illegal; it takes the longest wait so a bad setting fails safe.
  localparam int unsigned SBC_SETTLE_STATES [8] = '{
    8192, 16384, 32768, 65536, 131072, 262144, 1024, 262144};

  typedef enum logic [4:0] {
    SBC_RUN     = 5'h01,
    SBC_SWSTBY  = 5'h02,
    SBC_SETTLE  = 5'h04,
    SBC_HWSTBY  = 5'h08,
    SBC_RESHOLD = 5'h10
  } sbc_state_type;

  typedef struct packed {
    sbc_state_type state;
    logic hw_meta;
    logic hw_sync;
    logic res_meta;
    logic res_sync;
    logic nmi_meta;
    logic nmi_sync;
    logic nmi_prev;
    logic [SBC_IRQ_N-1:0] irq_meta;
    logic [SBC_IRQ_N-1:0] irq_sync;
    logic refresh_init;
    logic irq_exc;
    logic rst_exc;
    logic wake_nmi;
  } sbc_ctrl_type;

  // Reset, standby and IRQ pins are taken as idle (high) until the synchronisers fill; NMI starts low
  localparam sbc_ctrl_type SBC_CTRL_RESET = '{
    state: SBC_RUN, hw_meta: 1'h1, hw_sync: 1'h1, res_meta: 1'h1, res_sync: 1'h1,
    irq_meta: 3'h7, irq_sync: 3'h7, default: '0};

  typedef struct packed {
    logic [SBC_PRE_W-1:0] pre;
    logic [SBC_CNT_W-1:0] cnt;
    logic done;
  } sbc_tmr_type;

  localparam sbc_tmr_type SBC_TMR_RESET = '0;

endpackage : sbc_pkg
`default_nettype wire

// ---- hw/sbc_wait_if.sv ----
// Interface: settle wait request between the sequencer and its timer
`default_nettype none
interface sbc_wait_if;
  import sbc_pkg::*;
  logic run;
  logic [SBC_CNT_W-1:0] states;
  logic [SBC_DIV_W-1:0] div;
  logic done;
  modport ctrl (output run, output states, output div, input done);
  modport timer (input run, input states, input div, output done);
endinterface : sbc_wait_if
`default_nettype wire

// ---- hw/sbc_settle_timer.sv ----
// Settle timer: counts wait states on the prescaled clock
`default_nettype none
module sbc_settle_timer
  import sbc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  sbc_wait_if.timer wait_if
);

  sbc_tmr_type r_reg;
  sbc_tmr_type r_next;
  logic tick;
  logic [SBC_PRE_W-1:0] pre_last;
  logic [SBC_CNT_W+SBC_PRE_W-1:0] cyc_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    pre_last = SBC_PRE_W'((4'h1 << wait_if.div) - 4'h1);
    tick = (r_reg.pre == pre_last);
    r_next = r_reg;
    r_next.done = 1'b0;
    if (!wait_if.run || r_reg.done) begin
      r_next.pre = '0;
      r_next.cnt = '0;
    end else begin
      // One wait state per divided clock, so the absolute wait doubles per prescale step
      r_next.pre = tick ? '0 : r_reg.pre + 3'h1;
      if (tick) begin
        if (r_reg.cnt == wait_if.states - 19'h00001) begin
          r_next.done = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt + 19'h00001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_reg <= SBC_TMR_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign wait_if.done = r_reg.done;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cyc_reg <= '0;
    end else if (!wait_if.run) begin
      cyc_reg <= '0;
    end else begin
      cyc_reg <= cyc_reg + 22'h000001;
    end
  end

  AST_WAIT_LEN: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    wait_if.done |-> cyc_reg == ((SBC_CNT_W+SBC_PRE_W)'(wait_if.states) << wait_if.div))
    else $error("settle wait length differs from states times prescale");

endmodule : sbc_settle_timer
`default_nettype wire

// ---- hw/sbc_standby_ctrl.sv ----
// Standby mode controller: software and hardware standby sequencing
`default_nettype none
// Behaviour
// - sleep with standby-on-sleep set enters software standby
// - software standby halts CPU, clocks, resets modules
// - software standby keeps CPU, RAM, ports, refresh settings
// - entry clears refresh counter and control bits 7,6
// - only NMI, EXT_IRQ_PIN_0-2, reset, standby pin wake
// - interrupt wake waits settle time, then exception
// - disabled or masked IRQs do not wake
// - reset low restarts clocks; high starts reset exception
// - standby pin low moves to hardware standby
// - settle select picks 1024 to 262144 states
// - NMI edge select picks falling or rising wake
// - ports keep driving levels in software standby
// - standby pin low enters hardware standby from anywhere
// - hardware standby resets all but RAM, ports float
// - standby pin rise with reset low starts oscillator
module sbc_standby_ctrl
  import sbc_pkg::*;
#(
  parameter int unsigned SETTLE_STATES [8] = SBC_SETTLE_STATES
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic res_pin_n_i,
  input wire logic hw_standby_pin_n_i,
  input wire logic nmi_pin_i,
  input wire logic [SBC_IRQ_N-1:0] ext_irq_pin_n_i,
  input wire logic [SBC_IRQ_N-1:0] irq_enable_i,
  input wire logic [SBC_IRQ_N-1:0] irq_cpu_mask_i,
  input wire logic sleep_exec_i,
  input wire logic standby_on_sleep_i,
  input wire logic [SBC_STS_W-1:0] settle_time_select_i,
  input wire logic [SBC_DIV_W-1:0] clock_prescale_select_i,
  input wire logic nmi_edge_select_i,
  output logic cpu_halt_o,
  output logic clock_stop_o,
  output logic osc_run_o,
  output logic module_reset_o,
  output logic full_reset_o,
  output logic ctx_retain_o,
  output logic port_hold_o,
  output logic port_hiz_o,
  output logic refresh_init_o,
  output logic irq_exception_o,
  output logic reset_exception_o,
  output logic wake_by_nmi_o,
  output logic sw_standby_o,
  output logic hw_standby_o
);

  sbc_ctrl_type r_reg;
  sbc_ctrl_type r_next;
  logic nmi_edge;
  logic irq_wake;
  logic st_run;
  logic st_sw;
  logic st_settle;
  logic st_hw;
  logic st_res;

  sbc_wait_if wait_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Wake qualification
  always_comb begin
    // Falling edge when the select is 0, rising edge when 1
    if (nmi_edge_select_i) begin
      nmi_edge = r_reg.nmi_sync & ~r_reg.nmi_prev;
    end else begin
      nmi_edge = ~r_reg.nmi_sync & r_reg.nmi_prev;
    end
    // IRQ pins are active low; an enabled and unmasked level wakes
    irq_wake = |(~r_reg.irq_sync & irq_enable_i & ~irq_cpu_mask_i);
  end

  assign st_run = (r_reg.state == SBC_RUN);
  assign st_sw = (r_reg.state == SBC_SWSTBY);
  assign st_settle = (r_reg.state == SBC_SETTLE);
  assign st_hw = (r_reg.state == SBC_HWSTBY);
  assign st_res = (r_reg.state == SBC_RESHOLD);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    r_next = r_reg;
    r_next.hw_meta = hw_standby_pin_n_i;
    r_next.hw_sync = r_reg.hw_meta;
    r_next.res_meta = res_pin_n_i;
    r_next.res_sync = r_reg.res_meta;
    r_next.nmi_meta = nmi_pin_i;
    r_next.nmi_sync = r_reg.nmi_meta;
    r_next.nmi_prev = r_reg.nmi_sync;
    r_next.irq_meta = ext_irq_pin_n_i;
    r_next.irq_sync = r_reg.irq_meta;
    r_next.refresh_init = 1'b0;
    r_next.irq_exc = 1'b0;
    r_next.rst_exc = 1'b0;
    if (!r_reg.hw_sync) begin
      // Standby pin wins over every other source, whatever the state
      r_next.state = SBC_HWSTBY;
    end else begin
      case (r_reg.state)
        SBC_RUN: begin
          if (!r_reg.res_sync) begin
            r_next.state = SBC_RESHOLD;
          end else if (sleep_exec_i && standby_on_sleep_i) begin
            r_next.state = SBC_SWSTBY;
            r_next.refresh_init = 1'b1;
          end
        end
        SBC_SWSTBY: begin
          // Only the standby pin, reset or the listed interrupt pins leave this state
          if (!r_reg.res_sync) begin
            r_next.state = SBC_RESHOLD;
          end else if (nmi_edge || irq_wake) begin
            r_next.state = SBC_SETTLE;
            r_next.wake_nmi = nmi_edge;
          end
        end
        SBC_SETTLE: begin
          if (!r_reg.res_sync) begin
            r_next.state = SBC_RESHOLD;
          end else if (wait_if.done) begin
            r_next.state = SBC_RUN;
            r_next.irq_exc = 1'b1;
          end
        end
        SBC_HWSTBY: begin
          // Leaving with reset high is refused; the chip waits for reset low
          if (!r_reg.res_sync) begin
            r_next.state = SBC_RESHOLD;
          end
        end
        SBC_RESHOLD: begin
          if (r_reg.res_sync) begin
            r_next.state = SBC_RUN;
            r_next.rst_exc = 1'b1;
          end
        end
        default: begin
          r_next.state = SBC_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_reg <= SBC_CTRL_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settle timer; the select is read live, so software must not change it mid-wait
  assign wait_if.run = st_settle;
  assign wait_if.states = SBC_CNT_W'(SETTLE_STATES[settle_time_select_i]);
  assign wait_if.div = clock_prescale_select_i;

  sbc_settle_timer u_timer (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wait_if (wait_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cpu_halt_o = !st_run;
  // Clocks return at once on reset, but only after the wait on an interrupt
  assign clock_stop_o = st_sw | st_settle | st_hw;
  assign osc_run_o = !(st_sw | st_hw);
  assign module_reset_o = st_sw | st_settle | st_hw;
  assign full_reset_o = st_hw;
  assign ctx_retain_o = st_sw | st_settle;
  assign port_hold_o = st_sw | st_settle;
  assign port_hiz_o = st_hw;
  assign refresh_init_o = r_reg.refresh_init;
  assign irq_exception_o = r_reg.irq_exc;
  assign reset_exception_o = r_reg.rst_exc;
  assign wake_by_nmi_o = r_reg.wake_nmi;
  assign sw_standby_o = st_sw | st_settle;
  assign hw_standby_o = st_hw;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking sbc_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_quiet_standby;
    st_sw && r_reg.hw_sync && r_reg.res_sync && !nmi_edge && !irq_wake;
  endsequence

  sequence s_hw_release;
    st_hw && r_reg.hw_sync && !r_reg.res_sync;
  endsequence

  sequence s_reset_wait;
    st_res && !clock_stop_o && osc_run_o;
  endsequence

  AST_SLEEP_ENTER: assert property (
    st_run && r_reg.hw_sync && r_reg.res_sync && sleep_exec_i && standby_on_sleep_i
    |=> st_sw && cpu_halt_o)
    else $error("sleep with standby-on-sleep did not enter standby");

  AST_SW_HALT: assert property (
    st_sw |-> clock_stop_o && module_reset_o && cpu_halt_o && !osc_run_o)
    else $error("software standby left clocks or modules running");

  AST_RETAIN: assert property (
    sw_standby_o |-> ctx_retain_o && port_hold_o && !port_hiz_o && !full_reset_o)
    else $error("software standby lost retained state or ports");

  AST_REFRESH_INIT: assert property (
    $rose(st_sw) |-> refresh_init_o ##1 !refresh_init_o)
    else $error("refresh init pulse missing on standby entry");

  AST_NO_WAKE: assert property (
    s_quiet_standby |=> st_sw)
    else $error("software standby left without a wake source");

  AST_IRQ_WAKE: assert property (
    st_sw && r_reg.hw_sync && r_reg.res_sync && irq_wake |=> st_settle ##0 clock_stop_o)
    else $error("enabled interrupt did not start the settle wait");

  AST_SETTLE_END: assert property (
    st_settle && wait_if.done && r_reg.hw_sync && r_reg.res_sync
    |=> st_run && irq_exception_o && !clock_stop_o ##1 !irq_exception_o)
    else $error("settle end did not start interrupt exception");

  AST_RES_WAKE: assert property (
    st_sw && r_reg.hw_sync && !r_reg.res_sync |=> s_reset_wait)
    else $error("reset in standby did not restart clocks at once");

  AST_RES_EXIT: assert property (
    st_res && r_reg.hw_sync && r_reg.res_sync |=> st_run && reset_exception_o)
    else $error("reset release did not start reset exception");

  AST_HW_ENTER: assert property (
    !r_reg.hw_sync |=> hw_standby_o && port_hiz_o && full_reset_o)
    else $error("standby pin low did not enter hardware standby");

  AST_HW_EXIT: assert property (
    s_hw_release |=> s_reset_wait ##1 (st_res || st_run || st_hw))
    else $error("standby pin release did not start the oscillator");

  AST_NMI_WAKE: assert property (
    st_sw && r_reg.hw_sync && r_reg.res_sync && nmi_edge |=> st_settle && wake_by_nmi_o)
    else $error("selected NMI edge did not wake");

  sequence s_settle_busy;
    st_settle && !wait_if.done && r_reg.hw_sync && r_reg.res_sync;
  endsequence

  AST_SETTLE_HOLD: assert property (
    s_settle_busy |=> st_settle && clock_stop_o && osc_run_o && !irq_exception_o)
    else $error("settle wait ended before the timer finished");

  AST_SETTLE_RES: assert property (
    st_settle && r_reg.hw_sync && !r_reg.res_sync |=> s_reset_wait)
    else $error("reset during the settle wait did not restart clocks at once");

  AST_HW_STAY: assert property (
    st_hw && r_reg.hw_sync && r_reg.res_sync |=> st_hw && port_hiz_o)
    else $error("hardware standby left without reset low");

  AST_RUN_IGNORE: assert property (
    st_run && r_reg.hw_sync && r_reg.res_sync && !(sleep_exec_i && standby_on_sleep_i) |=> st_run)
    else $error("program execution left without sleep, reset or standby pin");

  AST_WAKE_SRC: assert property (
    !st_sw |=> $stable(wake_by_nmi_o))
    else $error("wake source flag changed outside software standby");

  AST_IRQ_PULSE: assert property (
    irq_exception_o |=> !irq_exception_o)
    else $error("interrupt exception request longer than one cycle");

  AST_RST_PULSE: assert property (
    reset_exception_o |=> !reset_exception_o)
    else $error("reset exception request longer than one cycle");

  AST_PORT_FLOAT: assert property (
    hw_standby_o |-> port_hiz_o && !port_hold_o && module_reset_o && cpu_halt_o)
    else $error("hardware standby left ports driven or modules running");

  AST_CLK_BACK: assert property (
    st_run |-> !clock_stop_o && !module_reset_o && osc_run_o && !cpu_halt_o)
    else $error("program execution without clocks or with modules in reset");

endmodule : sbc_standby_ctrl
`default_nettype wire

// ---- dv/sbc_ext_pins.sv ----
// External system model: drives the reset, standby, NMI and IRQ pins
`default_nettype none
module sbc_ext_pins
  import sbc_pkg::*;
(
  input wire logic ref_clk_i,
  output var logic res_pin_n_o,
  output var logic hw_standby_pin_n_o,
  output var logic nmi_pin_o,
  output var logic [SBC_IRQ_N-1:0] ext_irq_pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins idle high; mode pins are not modelled, so they never move
  initial begin
    res_pin_n_o = 1'h1;
    hw_standby_pin_n_o = 1'h1;
    nmi_pin_o = 1'h1;
    ext_irq_pin_n_o = 3'h7;
  end

  // Software is taken to clear RAM enable before the standby pin falls
  // Select: 0 reset, 1 standby, 2 NMI, 3 IRQ; levels change just after an edge
  task automatic drive(input int sel, input logic [2:0] v);
    @(posedge ref_clk_i);
    case (sel)
      0: res_pin_n_o <= v[0];
      1: hw_standby_pin_n_o <= v[0];
      2: nmi_pin_o <= v[0];
      default: ext_irq_pin_n_o <= v;
    endcase
  endtask : drive
endmodule : sbc_ext_pins
`default_nettype wire

// ---- dv/sbc_standby_ctrl_tb_top.sv ----
// Testbench for the standby mode controller
`default_nettype none
module sbc_standby_ctrl_tb_top
  import sbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic [2:0] sts; logic [1:0] div; logic [2:0] src; logic [15:0] exp;} sbc_row_type;
  // Short settle table keeps the run brief; expectations use the same table
  // Real settings must give at least 7 ms (crystal) or 100 us (external clock)
  localparam int unsigned ST [8] = '{8, 16, 32, 64, 128, 256, 4, 256};
  // src: 0 NMI fall, 1 NMI rise, 2..4 EXT_IRQ_PIN_0..2; exp = (ST[sts] << div) + 1
  localparam sbc_row_type ROWS [8] = '{
    '{3'h0, 2'h0, 3'h0, 16'h0009}, '{3'h1, 2'h1, 3'h1, 16'h0021}, '{3'h2, 2'h2, 3'h2, 16'h0081},
    '{3'h3, 2'h3, 3'h3, 16'h0201}, '{3'h4, 2'h0, 3'h4, 16'h0081}, '{3'h5, 2'h1, 3'h0, 16'h0201},
    '{3'h6, 2'h2, 3'h1, 16'h0011}, '{3'h7, 2'h3, 3'h2, 16'h0801}};

  logic ref_clk, reset_n, res_n, hw_n, nmi, sleep, sos, nmi_edge;
  logic [2:0] irq_n, irq_en, irq_mask, sts;
  logic [1:0] div;
  logic cpu_halt, clk_stop, osc_run, mod_rst, full_rst, ctx, hold, hiz;
  logic ref_init, irq_exc, rst_exc, wake_nmi, sw_sb, hw_sb;
  int mismatches, total_checks, n, k;

  sbc_ext_pins u_sbc_ext_pins (.ref_clk_i(ref_clk), .res_pin_n_o(res_n), .hw_standby_pin_n_o(hw_n),
    .nmi_pin_o(nmi), .ext_irq_pin_n_o(irq_n));

  sbc_standby_ctrl #(.SETTLE_STATES(ST)) u_sbc_standby_ctrl (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
    .res_pin_n_i(res_n), .hw_standby_pin_n_i(hw_n), .nmi_pin_i(nmi), .ext_irq_pin_n_i(irq_n),
    .irq_enable_i(irq_en), .irq_cpu_mask_i(irq_mask), .sleep_exec_i(sleep), .standby_on_sleep_i(sos),
    .settle_time_select_i(sts), .clock_prescale_select_i(div), .nmi_edge_select_i(nmi_edge),
    .cpu_halt_o(cpu_halt), .clock_stop_o(clk_stop), .osc_run_o(osc_run), .module_reset_o(mod_rst),
    .full_reset_o(full_rst), .ctx_retain_o(ctx), .port_hold_o(hold), .port_hiz_o(hiz),
    .refresh_init_o(ref_init), .irq_exception_o(irq_exc), .reset_exception_o(rst_exc),
    .wake_by_nmi_o(wake_nmi), .sw_standby_o(sw_sb), .hw_standby_o(hw_sb));

  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic finish_test();
    $display("mismatches %0d total_checks %0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // Sample just after the edge so the design's updates have landed
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wait_bit(ref logic s, input logic v, input string nm);
    for (int i = 0; i < 40; i++) begin
      tick(1);
      if (s === v) return;
    end
    chk(nm, 32'(v), 32'(s));
    finish_test();
  endtask : wait_bit

  // Software has cleared timer enable and bus release enable before sleeping
  task automatic enter_sw();
    @(posedge ref_clk);
    sleep <= 1'h1;
    @(posedge ref_clk);
    sleep <= 1'h0;
    #1;
    chk("swsb", 7'h7E, {sw_sb, ref_init, mod_rst, clk_stop, ctx, hold, osc_run});
    tick(1);
    chk("rinit", 1'h0, ref_init);
  endtask : enter_sw

  // Reset goes low first, then the standby pin rises, then reset is released
  task automatic hw_exit();
    u_sbc_ext_pins.drive(0, 3'h0);
    tick(6);
    chk("hwhold", 1'h1, hw_sb);
    u_sbc_ext_pins.drive(1, 3'h1);
    wait_bit(osc_run, 1'h1, "osc");
    chk("hwoff", 2'h0, {hw_sb, hiz});
    u_sbc_ext_pins.drive(0, 3'h1);
    wait_bit(rst_exc, 1'h1, "rexc");
  endtask : hw_exit

  initial begin
    {reset_n, sleep, nmi_edge, sts, div, irq_mask} = '0;
    sos = 1'h1;
    irq_en = 3'h7;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'h1;
    tick(1);
    chk("rst", 3'h1, {cpu_halt, hw_sb, osc_run});
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      sts <= ROWS[i].sts;
      div <= ROWS[i].div;
      nmi_edge <= (ROWS[i].src == 3'h1);
      if (ROWS[i].src == 3'h1)
        u_sbc_ext_pins.drive(2, 3'h0);
      tick(4);
      enter_sw();
      if (ROWS[i].src < 3'h2)
        u_sbc_ext_pins.drive(2, {2'h0, ROWS[i].src[0]});
      else
        u_sbc_ext_pins.drive(3, ~(3'h1 << (ROWS[i].src - 3'h2)));
      n = 0;
      for (k = 0; k < 3000 && irq_exc !== 1'h1; k++) begin
        tick(1);
        if (clk_stop && osc_run)
          n++;
      end
      chk("settle", 32'(ROWS[i].exp), 32'(n));
      chk("wake", {1'h0, ROWS[i].src < 3'h2, 2'h0}, {irq_exc ^ 1'h1, wake_nmi, cpu_halt, sw_sb});
      if (k == 3000) begin
        mismatches++;
        finish_test();
      end
      u_sbc_ext_pins.drive(3, 3'h7);
      u_sbc_ext_pins.drive(2, 3'h1);
      tick(4);
    end
    @(posedge ref_clk);
    sos <= 1'h0;
    tick(1);
    u_sbc_ext_pins.drive(2, 3'h1);
    @(posedge ref_clk);
    sleep <= 1'h1;
    @(posedge ref_clk);
    sleep <= 1'h0;
    tick(1);
    chk("nosb", 2'h0, {sw_sb, clk_stop});
    @(posedge ref_clk);
    sos <= 1'h1;
    irq_en <= 3'h0;
    nmi_edge <= 1'h1;
    tick(1);
    enter_sw();
    u_sbc_ext_pins.drive(3, 3'h6);
    tick(10);
    chk("irqoff", 2'h2, {sw_sb, osc_run});
    @(posedge ref_clk);
    irq_en <= 3'h7;
    irq_mask <= 3'h7;
    tick(10);
    chk("irqmask", 2'h2, {sw_sb, osc_run});
    u_sbc_ext_pins.drive(2, 3'h0);
    tick(10);
    chk("nmiedge", 2'h2, {sw_sb, osc_run});
    u_sbc_ext_pins.drive(0, 3'h0);
    wait_bit(osc_run, 1'h1, "resw");
    chk("reshold", 3'h0, {clk_stop, sw_sb, rst_exc});
    u_sbc_ext_pins.drive(0, 3'h1);
    wait_bit(rst_exc, 1'h1, "rexc");
    tick(1);
    chk("rexcp", 1'h0, rst_exc);
    u_sbc_ext_pins.drive(3, 3'h7);
    u_sbc_ext_pins.drive(2, 3'h1);
    irq_mask <= 3'h0;
    tick(4);
    enter_sw();
    // Reset pin in the middle of a long settle wait aborts it
    u_sbc_ext_pins.drive(3, 3'h6);
    tick(8);
    chk("setl", 3'h6, {clk_stop, osc_run, irq_exc});
    u_sbc_ext_pins.drive(0, 3'h0);
    tick(4);
    chk("setres", 4'h4, {clk_stop, osc_run, sw_sb, irq_exc});
    u_sbc_ext_pins.drive(3, 3'h7);
    u_sbc_ext_pins.drive(0, 3'h1);
    wait_bit(rst_exc, 1'h1, "rexc2");
    tick(4);
    enter_sw();
    u_sbc_ext_pins.drive(1, 3'h0);
    wait_bit(hw_sb, 1'h1, "hwsw");
    chk("hwst", 5'h1C, {hiz, full_rst, clk_stop, hold, ctx});
    hw_exit();
    u_sbc_ext_pins.drive(0, 3'h0);
    tick(4);
    u_sbc_ext_pins.drive(1, 3'h0);
    wait_bit(hw_sb, 1'h1, "hwrun");
    hw_exit();
    tick(4);
    finish_test();
  end
endmodule : sbc_standby_ctrl_tb_top
`default_nettype wire
